// ### rtl/acqc_consts.svh
// Purpose: register map, field positions, reset values and codes of the
//          acquisition mode and card command controller
// Assumes: register indices are word indices, byte address = index * 4
// Notes:   definitions only
`ifndef ACQC_CONSTS_SVH
`define ACQC_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define ACQC_IDX_CMD        16'h0064
`define ACQC_IDX_MODE       16'h251c
`define ACQC_IDX_AVAIL      16'h251d
`define ACQC_IDX_STATUS     16'h0070
`define ACQC_IDX_ERROR      16'h0071
`define ACQC_IDX_SETUP      16'h0072

// ----------------------------------------------------------------------
// command bit positions
// ----------------------------------------------------------------------
`define ACQC_CMD_RESET      0
`define ACQC_CMD_WRSETUP    1
`define ACQC_CMD_START      2
`define ACQC_CMD_TRIG_EN    3
`define ACQC_CMD_TRIG_FORCE 4
`define ACQC_CMD_TRIG_DIS   5
`define ACQC_CMD_STOP       6

// ----------------------------------------------------------------------
// status bit positions, setup fields, reset values, answer codes
// ----------------------------------------------------------------------
`define ACQC_STAT_RUN       0
`define ACQC_STAT_TRIG_EN   1
`define ACQC_STAT_DIRTY     2
`define ACQC_SETUP_GATE_LVL 8
`define ACQC_SETUP_LIVE     16'h00ff
`define ACQC_SETUP_RST      16'h0000
`define ACQC_MODE_RST       8'h01
`define ACQC_AVAIL_RST      8'hff
`define ACQC_ERR_OK         8'h00
`define ACQC_ERR_MODE       8'h01
`define ACQC_ERR_SEQ        8'h02
`define ACQC_HSIZE_WORD     3'h2

`endif

// ### rtl/acqc_pkg.sv
// Purpose: shared types of the acquisition mode and card command controller
// Assumes: constants come from acqc_consts.svh
// Notes:   types only
package acqc_pkg;

    typedef enum logic [1:0] {
        ACQC_IDLE = 2'b01,
        ACQC_RUN  = 2'b10
    } acqc_state_e;

    typedef struct packed {
        logic fifo;
        logic multi;
        logic gated;
        logic dual_rate;
    } acqc_flags_s;

    typedef struct packed {
        logic        en;
        logic [15:0] idx;
        logic [31:0] data;
    } acqc_wr_s;

    typedef struct packed {
        logic        wr_pend;
        logic        rd_pend;
        logic        ok;
        logic [15:0] idx;
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } acqc_ahb_s;

    typedef struct packed {
        acqc_state_e state;
        logic [7:0]  mode;
        acqc_flags_s flags;
        logic [15:0] setup;
        logic [15:0] hw_cfg;
        logic        dirty;
        logic        trig_en;
        logic [7:0]  err;
        logic        trigger;
        logic        setup_load;
        logic        hw_reset;
        logic        sample_en;
        logic        slow_en;
    } acqc_core_s;

endpackage

// ### rtl/acqc_onehot.sv
// Purpose: flags a vector with exactly one bit set
// Assumes: combinational
// Notes:   used to validate the operating mode bitmap
`timescale 1ns/1ps
module acqc_onehot #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] vec_i,
    output      logic         one_o
);
    assign one_o = (vec_i != '0) && ((vec_i & (vec_i - W'(1))) == '0);
endmodule

// ### rtl/acqc_ahb_slave.sv
// Purpose: AHB-Lite slave front end of the controller registers
// Assumes: single word transfers; response always OKAY
// Notes:   writes take no wait state, reads take one
`timescale 1ns/1ps
`include "acqc_consts.svh"
module acqc_ahb_slave
    import acqc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output      logic        hreadyout_o,
    output      logic        hresp_o,
    output      logic [31:0] hrdata_o,
    output      acqc_wr_s    wr_o,
    output      logic [15:0] rd_idx_o,
    input  wire logic [31:0] rdata_i
);
    acqc_ahb_s s;
    acqc_ahb_s next_s;
    logic      accept;

    localparam acqc_ahb_s AHB_RST = '{default: '0, hreadyout: 1'b1};

    assign accept = hsel_i && htrans_i[1] && hready_i;

    // ------------------------------------------------------------------
    // address phase capture, data phase answer
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.wr_pend = 1'b0;
        if (s.rd_pend) begin
            // unmapped or odd-sized reads answer zero
            next_s.hrdata    = s.ok ? rdata_i : 32'h0000_0000;
            next_s.hreadyout = 1'b1;
            next_s.rd_pend   = 1'b0;
        end
        if (accept) begin
            next_s.idx = haddr_i[17:2];
            next_s.ok  = (haddr_i[31:18] == 14'h0000) &&
                         (haddr_i[1:0] == 2'h0) &&
                         (hsize_i == `ACQC_HSIZE_WORD);
            if (hwrite_i) begin
                next_s.wr_pend = 1'b1;
            end else begin
                next_s.rd_pend   = 1'b1;
                next_s.hreadyout = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= AHB_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wr_o.en     = s.wr_pend && s.ok;
    assign wr_o.idx    = s.idx;
    assign wr_o.data   = hwdata_i;
    assign rd_idx_o    = s.idx;
    assign hreadyout_o = s.hreadyout;
    assign hresp_o     = s.hresp;
    assign hrdata_o    = s.hrdata;
endmodule

// ### rtl/acqc_ctrl.sv
// Purpose: operating mode select and card command interpreter
// Assumes: one clock; inputs synchronous to clk_i; AHB-Lite register access
// Notes:   every top output except run_o comes from a flip-flop
//
// What this block does
// - accept mode only with exactly one bit
// - mode register reads back mode in use
// - available modes map uses mode encoding
// - code 1h: memory, single trigger
// - code 2h: memory, equal-size multi trigger
// - code 4h: memory, sampling while gate level
// - code 8h: memory multi plus slow continuous
// - code 10h: streaming single trigger
// - 20h/40h/80h: streaming multi, gated, dual-rate
// - streaming modes use memory as fifo
// - command register is a bitmap
// - illegal command combination gives sequence error
// - bit 1h resets hardware and software state
// - bit 2h loads setup without starting
// - bit 4h starts, loading changed setup first
// - while running only live settings change
// - bit 8h enables trigger detection
// - bit 10h forces a trigger
// - bit 20h disables, triggers then ignored
// - start without bit 8h leaves trigger detection disabled
// - bit 40h stops; idle stop harmless
`timescale 1ns/1ps
`include "acqc_consts.svh"
module acqc_ctrl
    import acqc_pkg::*;
#(
    parameter logic [7:0] AVAIL_MODES = `ACQC_AVAIL_RST
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output      logic        hreadyout_o,
    output      logic        hresp_o,
    output      logic [31:0] hrdata_o,
    input  wire logic        trig_event_i,
    input  wire logic        gate_i,
    input  wire logic        run_done_i,
    output      logic [7:0]  mode_o,
    output      acqc_flags_s flags_o,
    output      logic        run_o,
    output      logic        trig_armed_o,
    output      logic        trigger_o,
    output      logic        setup_load_o,
    output      logic [15:0] hw_cfg_o,
    output      logic        hw_reset_o,
    output      logic        sample_en_o,
    output      logic        slow_sample_en_o
);
    acqc_core_s  s;
    acqc_core_s  next_s;
    acqc_wr_s    wr;
    logic [15:0] rd_idx;
    logic [31:0] rdata;
    logic        mode_one;
    logic [6:0]  cmd;
    logic        running;
    logic        trig_cmd;
    logic        seq_err;
    logic        armed_hit;

    localparam acqc_core_s CORE_RST = '{
        state:      ACQC_IDLE,
        mode:       `ACQC_MODE_RST,
        flags:      '0,
        setup:      `ACQC_SETUP_RST,
        hw_cfg:     `ACQC_SETUP_RST,
        dirty:      1'b0,
        trig_en:    1'b0,
        err:        `ACQC_ERR_OK,
        trigger:    1'b0,
        setup_load: 1'b0,
        hw_reset:   1'b0,
        sample_en:  1'b0,
        slow_en:    1'b0
    };

    // ------------------------------------------------------------------
    // bus front end and mode check
    // ------------------------------------------------------------------
    acqc_ahb_slave u_ahb (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .wr_o        (wr),
        .rd_idx_o    (rd_idx),
        .rdata_i     (rdata)
    );

    acqc_onehot #(
        .W (8)
    ) u_mode_chk (
        .vec_i (wr.data[7:0]),
        .one_o (mode_one)
    );

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    function automatic acqc_flags_s decode_mode(input logic [7:0] m);
        acqc_flags_s f;
        f.fifo      = |m[7:4];
        f.multi     = m[1] | m[3] | m[5] | m[7];
        f.gated     = m[2] | m[6];
        f.dual_rate = m[3] | m[7];
        return f;
    endfunction

    // ------------------------------------------------------------------
    // command legality
    // ------------------------------------------------------------------
    assign cmd      = wr.data[6:0];
    assign running  = (s.state == ACQC_RUN);
    assign armed_hit = running && s.trig_en && trig_event_i;
    assign trig_cmd = cmd[`ACQC_CMD_TRIG_EN] | cmd[`ACQC_CMD_TRIG_FORCE] |
                      cmd[`ACQC_CMD_TRIG_DIS];

    // reset must stand alone; start needs an idle card and no stop
    always_comb begin
        seq_err = 1'b0;
        if (cmd[`ACQC_CMD_RESET] && (cmd[6:1] != 6'h00)) begin
            seq_err = 1'b1;
        end
        if (cmd[`ACQC_CMD_START] && (running || cmd[`ACQC_CMD_STOP])) begin
            seq_err = 1'b1;
        end
        if (cmd[`ACQC_CMD_WRSETUP] && running) begin
            seq_err = 1'b1;
        end
        if (trig_cmd && !running && !cmd[`ACQC_CMD_START]) begin
            seq_err = 1'b1;
        end
        if (cmd[`ACQC_CMD_TRIG_EN] && cmd[`ACQC_CMD_TRIG_DIS]) begin
            seq_err = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // controller next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s            = s;
        next_s.trigger    = 1'b0;
        next_s.setup_load = 1'b0;
        next_s.hw_reset   = 1'b0;
        // run ends on its own
        if (running && run_done_i) begin
            next_s.state   = ACQC_IDLE;
            next_s.trig_en = 1'b0;
        end
        // events only count while detection is armed
        if (armed_hit) begin
            next_s.trigger = 1'b1;
        end
        if (wr.en) begin
            unique case (wr.idx)
                `ACQC_IDX_MODE: begin
                    if (running) begin
                        next_s.err = `ACQC_ERR_SEQ;
                    end else if (!mode_one ||
                                 ((wr.data[7:0] & ~AVAIL_MODES) != 8'h00) ||
                                 (wr.data[31:8] != 24'h0)) begin
                        next_s.err = `ACQC_ERR_MODE;
                    end else begin
                        next_s.mode  = wr.data[7:0];
                        next_s.flags = decode_mode(wr.data[7:0]);
                        next_s.err   = `ACQC_ERR_OK;
                    end
                end
                `ACQC_IDX_SETUP: begin
                    if (!running) begin
                        next_s.setup = wr.data[15:0];
                        next_s.dirty = 1'b1;
                        next_s.err   = `ACQC_ERR_OK;
                    end else if (((wr.data[15:0] ^ s.setup) &
                                  ~`ACQC_SETUP_LIVE) != 16'h0000) begin
                        next_s.err = `ACQC_ERR_SEQ;
                    end else begin
                        // live fields reach the hardware at once
                        next_s.setup  = wr.data[15:0];
                        next_s.hw_cfg = wr.data[15:0];
                        next_s.err    = `ACQC_ERR_OK;
                    end
                end
                `ACQC_IDX_CMD: begin
                    if (seq_err) begin
                        next_s.err = `ACQC_ERR_SEQ;
                    end else if (cmd[`ACQC_CMD_RESET]) begin
                        next_s          = CORE_RST;
                        next_s.hw_reset = 1'b1;
                    end else begin
                        next_s.err = `ACQC_ERR_OK;
                        if (cmd[`ACQC_CMD_WRSETUP] ||
                            (cmd[`ACQC_CMD_START] && s.dirty)) begin
                            next_s.hw_cfg     = s.setup;
                            next_s.dirty      = 1'b0;
                            next_s.setup_load = 1'b1;
                        end
                        if (cmd[`ACQC_CMD_START]) begin
                            next_s.state   = ACQC_RUN;
                            next_s.trig_en = 1'b0;
                        end
                        // enable lands after the start above
                        if (cmd[`ACQC_CMD_TRIG_EN]) begin
                            next_s.trig_en = 1'b1;
                        end
                        if (cmd[`ACQC_CMD_TRIG_DIS]) begin
                            next_s.trig_en = 1'b0;
                        end
                        if (cmd[`ACQC_CMD_TRIG_FORCE]) begin
                            next_s.trigger = 1'b1;
                        end
                        if (cmd[`ACQC_CMD_STOP] && running) begin
                            next_s.state   = ACQC_IDLE;
                            next_s.trig_en = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        next_s.sample_en = (next_s.state == ACQC_RUN) &&
                           (!next_s.flags.gated ||
                            (gate_i ==
                             next_s.hw_cfg[`ACQC_SETUP_GATE_LVL]));
        next_s.slow_en   = (next_s.state == ACQC_RUN) &&
                           next_s.flags.dual_rate;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= CORE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // register read data
    // ------------------------------------------------------------------
    always_comb begin
        unique case (rd_idx)
            `ACQC_IDX_MODE:   rdata = {24'h0, s.mode};
            `ACQC_IDX_AVAIL:  rdata = {24'h0, AVAIL_MODES};
            `ACQC_IDX_STATUS: rdata = {29'h0, s.dirty, s.trig_en, running};
            `ACQC_IDX_ERROR:  rdata = {24'h0, s.err};
            `ACQC_IDX_SETUP:  rdata = {16'h0, s.setup};
            default:          rdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign mode_o           = s.mode;
    assign flags_o          = s.flags;
    assign run_o            = running;
    assign trig_armed_o     = s.trig_en;
    assign trigger_o        = s.trigger;
    assign setup_load_o     = s.setup_load;
    assign hw_cfg_o         = s.hw_cfg;
    assign hw_reset_o       = s.hw_reset;
    assign sample_en_o      = s.sample_en;
    assign slow_sample_en_o = s.slow_en;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_cmd_wr;
        wr.en && (wr.idx == `ACQC_IDX_CMD) && !seq_err &&
            !cmd[`ACQC_CMD_RESET];
    endsequence

    sequence s_start_only;
        s_cmd_wr ##0 (cmd[`ACQC_CMD_START] && !cmd[`ACQC_CMD_TRIG_EN]);
    endsequence

    sequence s_start_arm;
        s_cmd_wr ##0 (cmd[`ACQC_CMD_START] && cmd[`ACQC_CMD_TRIG_EN]);
    endsequence

    a_mode_reject: assert property (
        (wr.en && wr.idx == `ACQC_IDX_MODE && !mode_one)
        |=> (s.err == ($past(running) ? `ACQC_ERR_SEQ : `ACQC_ERR_MODE)) &&
            $stable(s.mode))
        else $error("bad mode bitmap was accepted");

    a_mode_readback: assert property (
        (wr.en && wr.idx == `ACQC_IDX_MODE && !running && mode_one &&
         ((wr.data[7:0] & ~AVAIL_MODES) == 8'h00) &&
         wr.data[31:8] == 24'h0)
        |=> (mode_o == $past(wr.data[7:0])) &&
            (flags_o == decode_mode($past(wr.data[7:0]))))
        else $error("mode register does not hold the written mode");

    a_avail_read: assert property (
        (!hreadyout_o && (rd_idx == `ACQC_IDX_AVAIL) && u_ahb.s.ok)
        |=> hreadyout_o && (hrdata_o == {24'h0, AVAIL_MODES}))
        else $error("available modes read is wrong");

    a_fifo_flag: assert property (
        flags_o.fifo == (mode_o[7:4] != 4'h0))
        else $error("fifo flag disagrees with mode");

    a_seq_reject: assert property (
        (wr.en && wr.idx == `ACQC_IDX_CMD && seq_err)
        |=> (s.err == `ACQC_ERR_SEQ) && !setup_load_o && !hw_reset_o &&
            (trigger_o == $past(armed_hit)))
        else $error("illegal command combination took effect");

    a_reset_cmd: assert property (
        (wr.en && wr.idx == `ACQC_IDX_CMD && cmd == 7'h01)
        |=> hw_reset_o && !run_o && (mode_o == `ACQC_MODE_RST)
        ##1 !hw_reset_o)
        else $error("reset command misbehaved");

    a_setup_load: assert property (
        (s_cmd_wr ##0 (cmd == 7'h02))
        |=> setup_load_o && (hw_cfg_o == s.setup) && !run_o)
        else $error("setup write did not load the hardware");

    a_start_disarm: assert property (
        s_start_only |=> run_o && !trig_armed_o)
        else $error("start armed the trigger without enable");

    a_start_arm: assert property (
        s_start_arm |=> run_o && trig_armed_o)
        else $error("start with enable did not arm");

    a_no_trig_off: assert property (
        (!trig_armed_o && !wr.en) |=> !trigger_o)
        else $error("trigger passed while detection disabled");

    a_force_trig: assert property (
        (s_cmd_wr ##0 cmd[`ACQC_CMD_TRIG_FORCE]) |=> trigger_o ##1
        (!trigger_o || $past(trig_armed_o)))
        else $error("forced trigger missing");

    a_stop_idle: assert property (
        (s_cmd_wr ##0 (cmd == 7'h40) && !running)
        |=> !run_o && (s.err == `ACQC_ERR_OK) && $stable(trig_armed_o))
        else $error("stop on idle card had an effect");
endmodule

// ### testbench/acqc_ctrl_tb.sv
// Purpose: self-checking bench of the mode select and command controller
// Assumes: AHB-Lite single word transfers, hready fed back from hreadyout_o
// Notes:   one task per scenario; a cycle ceiling cuts a hang short
`timescale 1ns/1ps
`include "acqc_consts.svh"
module acqc_ctrl_tb;

    localparam logic [31:0] A_CMD   = {14'h0, `ACQC_IDX_CMD, 2'b00};
    localparam logic [31:0] A_MODE  = {14'h0, `ACQC_IDX_MODE, 2'b00};
    localparam logic [31:0] A_AVAIL = {14'h0, `ACQC_IDX_AVAIL, 2'b00};
    localparam logic [31:0] A_ERR   = {14'h0, `ACQC_IDX_ERROR, 2'b00};
    localparam logic [31:0] A_SETUP = {14'h0, `ACQC_IDX_SETUP, 2'b00};

    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = `ACQC_HSIZE_WORD;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic        trig_event_i = 1'b0;
    logic        gate_i = 1'b0;
    logic        run_done_i = 1'b0;
    logic        hreadyout_o;
    logic        hresp_o;
    logic [31:0] hrdata_o;
    logic [7:0]  mode_o;
    logic [3:0]  flags_o;
    logic        run_o;
    logic        trig_armed_o;
    logic        trigger_o;
    logic        setup_load_o;
    logic [15:0] hw_cfg_o;
    logic        hw_reset_o;
    logic        sample_en_o;
    logic        slow_sample_en_o;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;

    acqc_ctrl uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .trig_event_i(trig_event_i), .gate_i(gate_i),
        .run_done_i(run_done_i), .mode_o(mode_o), .flags_o(flags_o),
        .run_o(run_o), .trig_armed_o(trig_armed_o), .trigger_o(trigger_o),
        .setup_load_o(setup_load_o), .hw_cfg_o(hw_cfg_o),
        .hw_reset_o(hw_reset_o), .sample_en_o(sample_en_o),
        .slow_sample_en_o(slow_sample_en_o));

    always #2.5 clk_i = ~clk_i;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            print_verdict;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address phase held until hready, then data phase held until hready
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        r = hrdata_o;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        #1;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk(hresp_o, 1'b0);
    endtask

    task automatic ev(input logic exp);
        @(posedge clk_i);
        trig_event_i <= 1'b1;
        @(posedge clk_i);
        trig_event_i <= 1'b0;
        #1;
        chk(trigger_o, exp);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdchk(A_MODE, 32'h1);
        rdchk(A_AVAIL, 32'hff);
        rdchk(A_CMD, 32'h0);
        rdchk(32'h400, 32'h0);
    endtask

    task automatic t_modes;
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wr(A_MODE, {24'h0, m});
            chk(mode_o, m);
            chk(flags_o[3], i > 3);
            chk(flags_o[0], i == 3 || i == 7);
            chk(flags_o[2], i % 2 == 1);
            chk(flags_o[1], i % 4 == 2);
            rdchk(A_MODE, {24'h0, m});
        end
        wr(A_MODE, 32'h3);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_MODE});
        rdchk(A_MODE, 32'h80);
        wr(A_MODE, 32'h0);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_MODE});
    endtask

    task automatic t_run;
        wr(A_MODE, 32'h1);
        wr(A_SETUP, 32'h0105);
        wr(A_CMD, 32'h0c);
        chk(setup_load_o, 1'b1);
        chk(hw_cfg_o, 16'h0105);
        chk(run_o, 1'b1);
        chk(trig_armed_o, 1'b1);
        ev(1'b1);
        wr(A_CMD, 32'h20);
        chk(trig_armed_o, 1'b0);
        ev(1'b0);
        wr(A_CMD, 32'h10);
        chk(trigger_o, 1'b1);
        wr(A_CMD, 32'h04);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_SEQ});
        wr(A_SETUP, 32'h0007);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_SEQ});
        wr(A_SETUP, 32'h0107);
        chk(hw_cfg_o, 16'h0107);
        wr(A_CMD, 32'h40);
        chk(run_o, 1'b0);
        wr(A_CMD, 32'h40);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_OK});
    endtask

    task automatic t_gate;
        wr(A_MODE, 32'h4);
        chk(flags_o[1], 1'b1);
        wr(A_CMD, 32'h04);
        chk(sample_en_o, 1'b0);
        @(posedge clk_i);
        gate_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk(sample_en_o, 1'b1);
        chk(slow_sample_en_o, 1'b0);
        wr(A_CMD, 32'h40);
        wr(A_MODE, 32'h8);
        wr(A_CMD, 32'h04);
        chk(slow_sample_en_o, 1'b1);
        chk(sample_en_o, 1'b1);
        wr(A_CMD, 32'h40);
        chk(slow_sample_en_o, 1'b0);
    endtask

    task automatic t_cmd;
        wr(A_CMD, 32'h05);
        rdchk(A_ERR, {24'h0, `ACQC_ERR_SEQ});
        chk(run_o, 1'b0);
        wr(A_CMD, 32'h04);
        chk(trig_armed_o, 1'b0);
        ev(1'b0);
        @(posedge clk_i);
        run_done_i <= 1'b1;
        @(posedge clk_i);
        run_done_i <= 1'b0;
        #1;
        chk(run_o, 1'b0);
        wr(A_SETUP, 32'h0033);
        wr(A_CMD, 32'h02);
        chk(setup_load_o, 1'b1);
        chk(hw_cfg_o, 16'h0033);
        chk(run_o, 1'b0);
        wr(A_MODE, 32'h10);
        wr(A_CMD, 32'h01);
        chk(hw_reset_o, 1'b1);
        chk(mode_o, `ACQC_MODE_RST);
        chk(hw_cfg_o, `ACQC_SETUP_RST);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset;
        t_modes;
        t_run;
        t_gate;
        t_cmd;
        print_verdict;
    end

endmodule
